//--- src/touch_link_pkg.sv
package touch_link_pkg;
  // device clock
  localparam int CLK_PERIOD_PS = 5000;
  // least time the handshake stays low after each byte
  localparam int READY_LOW_MIN_NS = 1000;
  localparam int READY_LOW_CYC = (READY_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // least time the handshake stays low after reset
  localparam int RESET_LOW_MIN_MS = 1;
  localparam int RESET_LOW_CYC = (RESET_LOW_MIN_MS * 1000000000 + CLK_PERIOD_PS - 1)
                                 / CLK_PERIOD_PS;
  // longest period of the full self-test set
  localparam int SELFTEST_PERIOD_MS = 1000;
  localparam longint SELFTEST_CYC_L = 64'(SELFTEST_PERIOD_MS) * 64'd1000000000
                                      / 64'(CLK_PERIOD_PS);
  localparam int SELFTEST_CYC = int'(SELFTEST_CYC_L);
  localparam int CNT_W = 32;
  // commands
  localparam logic [7:0] CMD_NULL = 8'h00;
  localparam logic [7:0] CMD_STATUS = 8'h05;
  localparam logic [7:0] CMD_FIRST_KEY = 8'h06;
  localparam logic [7:0] CMD_ALL_KEYS = 8'h07;
  localparam logic [7:0] CMD_FAULTS = 8'h0b;
  localparam logic [7:0] CMD_KEY_ERR = 8'h0c;
  localparam logic [7:0] CMD_ECHO = 8'h0f;
  // general status byte
  localparam int ST_COMM_ERR_BIT = 7;
  localparam int ST_ANY_ERR_BIT = 6;
  // first-key report byte
  localparam int FK_ERR_BIT = 7;
  localparam int FK_DET_BIT = 6;
  localparam int FK_IDX_LSB = 0;
  // crc generator polynomial, x^8 implied
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // matrix and fault vector
  localparam int NUM_KEYS = 24;
  localparam int KEY_IDX_W = 5;
  localparam int FAULT_W = 7;
  // response buffer
  localparam int BUF_AW = 3;
  localparam int BUF_DEPTH = 8;
  typedef enum logic [1:0] {BLD_IDLE, BLD_DATA, BLD_CRC} build_state_t;
  typedef enum logic [1:0] {SC_WAIT, SC_KEY, SC_DUMMY} scan_state_t;
  // msb-first crc-8 step over one byte
  function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
  // lowest numbered key in detect, zero when none
  function automatic logic [KEY_IDX_W-1:0] first_key(input logic [NUM_KEYS-1:0] det);
    logic [KEY_IDX_W-1:0] idx;
    idx = '0;
    for (int i = NUM_KEYS - 1; i >= 0; i--) begin
      if (det[i]) begin
        idx = KEY_IDX_W'(i);
      end
    end
    return idx;
  endfunction
endpackage

//--- src/resp_buffer.sv
`timescale 1ns/10ps
module resp_buffer (
  input wire logic mclk, // device clock
  input wire logic wr_en, // write strobe
  input wire logic [touch_link_pkg::BUF_AW-1:0] wr_addr, // write address
  input wire logic [7:0] wr_data, // write byte
  input wire logic [touch_link_pkg::BUF_AW-1:0] rd_addr, // read address
  output logic [7:0] rd_data // registered read byte
);
  import touch_link_pkg::*;
  logic [7:0] mem [BUF_DEPTH];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    rd_data <= mem[rd_addr];
  end
endmodule // resp_buffer

//--- src/touch_host_link.sv
`timescale 1ns/10ps
module touch_host_link #(
  parameter int RESET_LOW_CYCLES = touch_link_pkg::RESET_LOW_CYC, // ready low after reset
  parameter int SELFTEST_CYCLES = touch_link_pkg::SELFTEST_CYC // self-test scan period
) (
  input wire logic mclk, // device clock
  input wire logic reset, // synchronous reset
  input wire logic spi_sck, // serial clock pin
  input wire logic spi_ss_n, // slave select pin
  input wire logic spi_mosi, // serial data in pin
  output logic spi_miso_o, // serial data out
  output logic spi_miso_oe, // serial data out enable
  output logic link_ready_handshake_o, // open-drain level, always low
  output logic link_ready_handshake_oe, // pulls the line low when high
  input wire logic [touch_link_pkg::NUM_KEYS-1:0] key_enable, // enabled keys
  input wire logic [touch_link_pkg::NUM_KEYS-1:0] key_detect, // keys in detect
  output logic [touch_link_pkg::KEY_IDX_W-1:0] key_sel, // key being checked
  input wire logic [7:0] key_level, // signal level of key_sel
  input wire logic [7:0] low_signal_limit, // minimum key level
  input wire logic [touch_link_pkg::FAULT_W-1:0] fault_result, // front-end test results
  output logic selftest_slot // pulse in the dummy slot
);
  import touch_link_pkg::*;

  // pin synchronisers: sck, ss_n, mosi
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic sck_d_reg;
  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1_reg <= 3'h3;
      sync2_reg <= 3'h3;
      sck_d_reg <= 1'b1;
    end else begin
      sync1_reg <= {spi_mosi, spi_ss_n, spi_sck};
      sync2_reg <= sync1_reg;
      sck_d_reg <= sync2_reg[0];
    end
  end
  logic sck_s;
  logic ss_s;
  logic mosi_s;
  logic sck_rise;
  logic sck_fall;
  assign sck_s = sync2_reg[0];
  assign ss_s = sync2_reg[1];
  assign mosi_s = sync2_reg[2];
  assign sck_rise = sck_s & ~sck_d_reg & ~ss_s;
  assign sck_fall = ~sck_s & sck_d_reg & ~ss_s;
  // receive shifter, framed by slave select
  logic [7:0] rx_shift_reg;
  logic [2:0] bit_cnt_reg;
  logic byte_done_reg;
  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      byte_done_reg <= 1'b0;
    end else begin
      byte_done_reg <= 1'b0;
      if (ss_s) begin
        bit_cnt_reg <= 3'h0;
      end else if (sck_rise) begin
        rx_shift_reg <= {rx_shift_reg[6:0], mosi_s};
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        byte_done_reg <= (bit_cnt_reg == 3'h7);
      end
    end
  end
  // response buffer state
  build_state_t bld_state_reg;
  logic [BUF_AW-1:0] head_reg;
  logic [BUF_AW-1:0] resp_left_reg;
  logic [BUF_AW-1:0] bld_idx_reg;
  logic [BUF_AW-1:0] bld_len_reg;
  logic [31:0] pay_reg;
  logic crc_en_reg;
  logic [7:0] crc_reg;
  logic [7:0] rd_data;
  logic wr_en;
  logic [BUF_AW-1:0] wr_addr;
  logic [7:0] wr_data;
  // transmit shifter: loads the head byte between bytes
  logic [7:0] tx_shift_reg;
  logic tx_busy_reg;
  logic miso_reg;
  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_shift_reg <= 8'h00;
      tx_busy_reg <= 1'b0;
      miso_reg <= 1'b0;
    end else if (ss_s || byte_done_reg) begin
      tx_busy_reg <= 1'b0;
    end else if (sck_fall) begin
      miso_reg <= tx_shift_reg[7];
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
      tx_busy_reg <= 1'b1;
    end else if (!tx_busy_reg) begin
      tx_shift_reg <= (resp_left_reg != '0) ? rd_data : 8'h00;
    end
  end
  assign spi_miso_o = miso_reg;
  assign spi_miso_oe = ~ss_s;
  // self-test results
  logic [NUM_KEYS-1:0] key_err_reg;
  logic [FAULT_W-1:0] fault_err_reg;
  logic comm_err_reg;
  logic any_err;
  assign any_err = (|key_err_reg) | (|fault_err_reg);
  // bytes received before the last response byte are only nulls; the byte sent with the last one can carry a command
  logic take_cmd;
  logic cmd_accept;
  logic [31:0] pay_next;
  logic [BUF_AW-1:0] len_next;
  logic crc_next;
  logic unknown_cmd;
  assign take_cmd = byte_done_reg && (resp_left_reg <= BUF_AW'(1));
  assign cmd_accept = take_cmd && (rx_shift_reg != CMD_NULL);
  always_comb begin
    pay_next = 32'h0;
    len_next = '0;
    crc_next = 1'b1;
    unknown_cmd = 1'b0;
    unique case (rx_shift_reg)
      CMD_NULL: begin
        crc_next = 1'b0;
      end
      CMD_STATUS: begin
        pay_next[ST_COMM_ERR_BIT] = comm_err_reg;
        pay_next[ST_ANY_ERR_BIT] = any_err;
        len_next = BUF_AW'(1);
      end
      CMD_FIRST_KEY: begin
        pay_next[FK_ERR_BIT] = any_err;
        pay_next[FK_DET_BIT] = |key_detect;
        pay_next[FK_IDX_LSB +: KEY_IDX_W] = first_key(key_detect);
        len_next = BUF_AW'(1);
      end
      CMD_ALL_KEYS: begin
        pay_next[NUM_KEYS-1:0] = key_detect;
        len_next = BUF_AW'(3);
      end
      CMD_FAULTS: begin
        pay_next[FAULT_W-1:0] = fault_err_reg;
        len_next = BUF_AW'(1);
      end
      CMD_KEY_ERR: begin
        pay_next[NUM_KEYS-1:0] = key_err_reg;
        len_next = BUF_AW'(3);
      end
      CMD_ECHO: begin
        pay_next[7:0] = ~rx_shift_reg;
        len_next = BUF_AW'(1);
        crc_next = 1'b0;
      end
      default: begin
        unknown_cmd = 1'b1;
        crc_next = 1'b0;
      end
    endcase
  end

  // builds payload then, when crc_en_reg is set, crc into the buffer, one byte a cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      bld_state_reg <= BLD_IDLE;
      head_reg <= '0;
      resp_left_reg <= '0;
      bld_idx_reg <= '0;
      bld_len_reg <= '0;
      pay_reg <= 32'h0;
      crc_en_reg <= 1'b0;
      crc_reg <= CRC_INIT;
    end else begin
      if (byte_done_reg && resp_left_reg != '0) begin
        head_reg <= head_reg + BUF_AW'(1);
        resp_left_reg <= resp_left_reg - BUF_AW'(1);
      end
      unique case (bld_state_reg)
        BLD_IDLE: begin
          if (cmd_accept && len_next != '0) begin
            pay_reg <= pay_next;
            bld_len_reg <= len_next;
            crc_en_reg <= crc_next;
            bld_idx_reg <= '0;
            crc_reg <= CRC_INIT;
            bld_state_reg <= BLD_DATA;
          end
        end
        BLD_DATA: begin
          crc_reg <= crc8(crc_reg, pay_reg[7:0]);
          pay_reg <= {8'h00, pay_reg[31:8]};
          bld_idx_reg <= bld_idx_reg + BUF_AW'(1);
          if (bld_idx_reg == bld_len_reg - BUF_AW'(1)) begin
            if (crc_en_reg) begin
              bld_state_reg <= BLD_CRC;
            end else begin
              head_reg <= '0;
              resp_left_reg <= bld_len_reg;
              bld_state_reg <= BLD_IDLE;
            end
          end
        end
        BLD_CRC: begin
          head_reg <= '0;
          resp_left_reg <= bld_len_reg + BUF_AW'(1);
          bld_state_reg <= BLD_IDLE;
        end
      endcase
    end
  end
  assign wr_en = (bld_state_reg == BLD_DATA) || (bld_state_reg == BLD_CRC);
  assign wr_addr = bld_idx_reg;
  assign wr_data = (bld_state_reg == BLD_CRC) ? crc_reg : pay_reg[7:0];
  resp_buffer u_resp_buffer (
    .mclk(mclk),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(head_reg),
    .rd_data(rd_data)
  );
  // communications error, set wins over clear by status read
  always_ff @(posedge mclk) begin
    if (reset) begin
      comm_err_reg <= 1'b0;
    end else if (cmd_accept && unknown_cmd) begin
      comm_err_reg <= 1'b1;
    end else if (cmd_accept && rx_shift_reg == CMD_STATUS) begin
      comm_err_reg <= 1'b0;
    end
  end
  // handshake: low at once after each byte, high when idle again
  logic ready_reg;
  logic [CNT_W-1:0] busy_cnt_reg;
  always_ff @(posedge mclk) begin
    if (reset) begin
      ready_reg <= 1'b0;
      busy_cnt_reg <= CNT_W'(RESET_LOW_CYCLES);
    end else if (byte_done_reg) begin
      ready_reg <= 1'b0;
      busy_cnt_reg <= CNT_W'(READY_LOW_CYC - 1);
    end else if (busy_cnt_reg != '0) begin
      busy_cnt_reg <= busy_cnt_reg - CNT_W'(1);
    end else if (bld_state_reg == BLD_IDLE) begin
      // unknown commands build nothing, so release comes straight after
      ready_reg <= 1'b1;
    end
  end
  assign link_ready_handshake_o = 1'b0;
  assign link_ready_handshake_oe = ~ready_reg;

  // periodic key scan with a trailing self-test slot
  scan_state_t scan_state_reg;
  logic [CNT_W-1:0] period_cnt_reg;
  logic [KEY_IDX_W-1:0] key_idx_reg;
  logic [NUM_KEYS-1:0] key_work_reg;
  logic slot_reg;
  always_ff @(posedge mclk) begin
    if (reset) begin
      period_cnt_reg <= '0;
    end else if (period_cnt_reg == '0) begin
      period_cnt_reg <= CNT_W'(SELFTEST_CYCLES - 1);
    end else begin
      period_cnt_reg <= period_cnt_reg - CNT_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      scan_state_reg <= SC_WAIT;
      key_idx_reg <= '0;
      key_work_reg <= '0;
      key_err_reg <= '0;
      fault_err_reg <= '0;
      slot_reg <= 1'b0;
    end else begin
      slot_reg <= 1'b0;
      unique case (scan_state_reg)
        SC_WAIT: begin
          if (period_cnt_reg == '0) begin
            key_idx_reg <= '0;
            key_work_reg <= '0;
            scan_state_reg <= SC_KEY;
          end
        end
        SC_KEY: begin
          // disabled keys are passed over without a check
          if (key_enable[key_idx_reg] && key_level < low_signal_limit) begin
            key_work_reg[key_idx_reg] <= 1'b1;
          end
          if (key_idx_reg == KEY_IDX_W'(NUM_KEYS - 1)) begin
            scan_state_reg <= SC_DUMMY;
            slot_reg <= 1'b1;
          end else begin
            key_idx_reg <= key_idx_reg + KEY_IDX_W'(1);
          end
        end
        SC_DUMMY: begin
          // results replace the last round; persistence is left to the host
          key_err_reg <= key_work_reg & key_enable;
          fault_err_reg <= (|key_enable) ? fault_result : '0;
          scan_state_reg <= SC_WAIT;
        end
        default: begin
          scan_state_reg <= SC_WAIT;
        end
      endcase
    end
  end
  assign key_sel = key_idx_reg;
  assign selftest_slot = slot_reg;
endmodule // touch_host_link

//--- verification/touch_host_link_chk.sv
`timescale 1ns/10ps
module touch_host_link_chk #(
  parameter int RESET_LOW_CYCLES = 20,
  parameter int SELFTEST_CYCLES = 64
) (
  input wire logic mclk, // device clock
  input wire logic reset, // synchronous reset
  input wire logic spi_sck, // serial clock pin
  input wire logic spi_ss_n, // slave select pin
  input wire logic spi_miso_o, // serial data out
  input wire logic spi_miso_oe, // serial data out enable
  input wire logic link_ready_handshake_o, // open-drain level
  input wire logic link_ready_handshake_oe, // pull-down enable
  input wire logic [touch_link_pkg::KEY_IDX_W-1:0] key_sel, // key being checked
  input wire logic selftest_slot // dummy slot pulse
);
  import touch_link_pkg::*;
  logic sck_q_reg;
  logic [2:0] bit_cnt_reg;
  int gap_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  always_ff @(posedge mclk) begin
    sck_q_reg <= spi_sck;
  end
  // counted at the pin, so the figure includes the design's synchroniser
  always_ff @(posedge mclk) begin
    if (reset || spi_ss_n) begin
      bit_cnt_reg <= 3'h0;
    end else if (spi_sck && !sck_q_reg) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (reset || selftest_slot) begin
      gap_reg <= 0;
    end else begin
      gap_reg <= gap_reg + 1;
    end
  end
  property p_slot_one;
    selftest_slot |=> !selftest_slot;
  endproperty
  a_slot_one: assert property (p_slot_one)
    else $error("slot pulse too long");
  property p_slot_last;
    selftest_slot |-> key_sel == KEY_IDX_W'(NUM_KEYS - 1);
  endproperty
  a_slot_last: assert property (p_slot_last)
    else $error("slot not after last key");
  property p_period;
    gap_reg <= SELFTEST_CYCLES + 32;
  endproperty
  a_period: assert property (p_period)
    else $error("self-test period too long");
  property p_busy;
    spi_sck && !sck_q_reg && bit_cnt_reg == 3'h7 && !spi_ss_n |-> ##[1:12] link_ready_handshake_oe;
  endproperty
  a_busy: assert property (p_busy)
    else $error("no busy after byte");
  property p_low_min;
    $rose(link_ready_handshake_oe) |-> link_ready_handshake_oe [*8];
  endproperty
  a_low_min: assert property (p_low_min)
    else $error("busy low too short");
  property p_od_level;
    link_ready_handshake_o == 1'b0;
  endproperty
  a_od_level: assert property (p_od_level)
    else $error("handshake driven high");
  property p_float;
    spi_ss_n [*4] |-> !spi_miso_oe;
  endproperty
  a_float: assert property (p_float)
    else $error("data out driven while deselected");
  property p_drive;
    !spi_ss_n [*4] |-> spi_miso_oe;
  endproperty
  a_drive: assert property (p_drive)
    else $error("data out not driven while selected");
  property p_shift_fall;
    !spi_ss_n && !$past(spi_ss_n) && $changed(spi_miso_o) |-> !spi_sck;
  endproperty
  a_shift_fall: assert property (p_shift_fall)
    else $error("data out changed while clock high");
endmodule // touch_host_link_chk

bind touch_host_link touch_host_link_chk #(
  .RESET_LOW_CYCLES(RESET_LOW_CYCLES),
  .SELFTEST_CYCLES(SELFTEST_CYCLES)
) chk (.mclk, .reset, .spi_sck, .spi_ss_n, .spi_miso_o, .spi_miso_oe, .link_ready_handshake_o,
  .link_ready_handshake_oe, .key_sel, .selftest_slot);

//--- verification/spi_host_model.sv
`timescale 1ns/10ps
module spi_host_model (
  input wire logic mclk, // device clock, polling only
  input wire logic ready_wire, // handshake line level
  input wire logic miso, // serial data from device
  output logic sck, // serial clock
  output logic ss_n, // slave select
  output logic mosi // serial data to device
);
  initial begin
    sck = 1'b1;
    ss_n = 1'b1;
    mosi = 1'b1;
  end
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ok);
    int n;
    logic low_seen;
    logic hi_ok;
    n = 0;
    low_seen = 1'b0;
    while (ready_wire !== 1'b1 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    // a handshake that never comes back high fails the byte
    hi_ok = (ready_wire === 1'b1);
    ss_n = 1'b0;
    #103;
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      mosi = tx[i];
      #40;
      sck = 1'b1;
      rx[i] = miso;
      if (i > 0) #40;
    end
    // deselect early so a reloaded output byte is never seen mid-frame
    #10;
    ss_n = 1'b1;
    mosi = ~tx[0];
    n = 0;
    // at most 40 us for the busy low; ready is awaited again next byte
    while (!low_seen && n < 8000) begin
      @(posedge mclk);
      low_seen = (ready_wire === 1'b0);
      n++;
    end
    ok = low_seen && hi_ok;
  endtask
endmodule // spi_host_model

//--- verification/touch_host_link_bench.sv
`timescale 1ns/10ps
module touch_host_link_bench;
  import touch_link_pkg::*;
  localparam int RST_LOW = 20;
  localparam int SCAN = 64;
  logic mclk, reset, spi_sck, spi_ss_n, spi_mosi, spi_miso_o, spi_miso_oe, selftest_slot;
  logic link_ready_handshake_o, link_ready_handshake_oe;
  logic [NUM_KEYS-1:0] key_enable, key_detect;
  logic [KEY_IDX_W-1:0] key_sel;
  logic [7:0] key_level, low_signal_limit;
  logic [FAULT_W-1:0] fault_result;
  wire ready_wire = link_ready_handshake_oe ? link_ready_handshake_o : 1'b1;
  wire miso_wire = spi_miso_oe ? spi_miso_o : 1'bz;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  // keys 3 and 9 weak; key 9 is disabled
  assign key_level = (key_sel == 5'd3 || key_sel == 5'd9) ? 8'h10 : 8'h80;
  touch_host_link #(.RESET_LOW_CYCLES(RST_LOW), .SELFTEST_CYCLES(SCAN)) DUT (
    .mclk(mclk), .reset(reset), .spi_sck(spi_sck), .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi),
    .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe),
    .link_ready_handshake_o(link_ready_handshake_o),
    .link_ready_handshake_oe(link_ready_handshake_oe), .key_enable(key_enable),
    .key_detect(key_detect), .key_sel(key_sel), .key_level(key_level),
    .low_signal_limit(low_signal_limit), .fault_result(fault_result),
    .selftest_slot(selftest_slot));
  spi_host_model host (.mclk(mclk), .ready_wire(ready_wire), .miso(miso_wire), .sck(spi_sck),
    .ss_n(spi_ss_n), .mosi(spi_mosi));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      $display("MISMATCH at %0t: cycles %h limit %h", $time, cycles, 40000);
      conclude();
    end
  end
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int k = 0; k < 8; k++) r = r[7] ? {r[6:0], 1'b0} ^ CRC_POLY : {r[6:0], 1'b0};
    return r;
  endfunction
  task automatic xf(input logic [7:0] tx, output logic [7:0] rx);
    logic ok;
    host.xfer(tx, rx, ok);
    cmp({7'h0, ok}, 8'h01);
  endtask
  // command, then one null per payload byte and, when crc_on is set, one for the check byte
  task automatic query(input logic [7:0] c, input int n, input logic [23:0] exp, input bit crc_on);
    logic [7:0] rx;
    logic [7:0] crc;
    crc = CRC_INIT;
    xf(c, rx);
    for (int i = 0; i < n; i++) begin
      xf(CMD_NULL, rx);
      cmp(rx, exp[8*i +: 8]);
      crc = crc8(crc, exp[8*i +: 8]);
    end
    if (crc_on) begin
      xf(CMD_NULL, rx);
      cmp(rx, crc);
    end
  endtask
  task automatic wait_scan();
    int n;
    n = 0;
    while (selftest_slot !== 1'b1 && n < 2 * SCAN) begin
      @(posedge mclk);
      #1;
      n++;
    end
    cmp({7'h0, selftest_slot}, 8'h01);
    repeat (3) @(posedge mclk);
  endtask
  task automatic t_reset();
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    repeat (RST_LOW - 4) @(posedge mclk);
    #1;
    cmp({7'h0, ready_wire}, 8'h00);
    cmp({7'h0, spi_miso_oe}, 8'h00);
    repeat (12) @(posedge mclk);
    #1;
    cmp({7'h0, ready_wire}, 8'h01);
  endtask
  task automatic t_link();
    query(CMD_ECHO, 1, 24'hf0, 1'b0);
    query(8'h33, 1, 24'h00, 1'b0);
    query(CMD_STATUS, 1, 24'hc0, 1'b1);
    query(CMD_STATUS, 1, 24'h40, 1'b1);
  endtask
  // polls are spaced by a scan period, scaled down from the host's interval
  task automatic t_faults();
    wait_scan();
    query(CMD_FIRST_KEY, 1, 24'hc5, 1'b1);
    query(CMD_ALL_KEYS, 3, 24'h100020, 1'b1);
    query(CMD_FAULTS, 1, 24'h55, 1'b1);
    query(CMD_KEY_ERR, 3, 24'h000008, 1'b1);
    wait_scan();
    query(CMD_FAULTS, 1, 24'h55, 1'b1);
  endtask
  task automatic t_disabled();
    @(posedge mclk);
    key_enable <= '0;
    key_detect <= '0;
    wait_scan();
    wait_scan();
    query(CMD_FIRST_KEY, 1, 24'h00, 1'b1);
    query(CMD_FAULTS, 1, 24'h00, 1'b1);
    query(CMD_KEY_ERR, 3, 24'h000000, 1'b1);
  endtask
  initial begin
    reset = 1'b1;
    key_enable = 24'hfffdff;
    key_detect = 24'h100020;
    low_signal_limit = 8'h40;
    fault_result = 7'h55;
    t_reset();
    t_link();
    t_faults();
    t_disabled();
    conclude();
  end
endmodule // touch_host_link_bench
